// file: verilog/sgmx_pkg.sv
// Constants, types and register map of the signal mixer unit.
// Assumes an 8-bit register port and one 125 MHz system clock.

package sgmx_pkg;

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 8;

   localparam logic [11:0] OFS_MIXER_CONTROL_ZERO = 12'h897;
   localparam logic [11:0] OFS_MIXER_CONTROL_ONE  = 12'h898;
   localparam logic [11:0] OFS_KEYING_SOURCE_REG  = 12'h899;
   localparam logic [11:0] OFS_LOWER_CARRIER_REG  = 12'h89A;
   localparam logic [11:0] OFS_UPPER_CARRIER_REG  = 12'h89B;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned BIT_ENABLE        = 7;
   localparam int unsigned BIT_OUT_STATUS    = 5;
   localparam int unsigned BIT_OUTPUT_INVERT = 4;
   localparam int unsigned BIT_SW_KEYING     = 0;
   localparam int unsigned BIT_UPPER_INVERT  = 5;
   localparam int unsigned BIT_UPPER_SYNC    = 4;
   localparam int unsigned BIT_LOWER_INVERT  = 1;
   localparam int unsigned BIT_LOWER_SYNC    = 0;
   localparam int unsigned KEY_FIELD_W       = 5;
   localparam int unsigned CAR_FIELD_W       = 4;

   // ----------------------------------------------------------------
   // Source codes
   // ----------------------------------------------------------------
   localparam logic [4:0] KEY_SRC_PIN      = 5'h00;
   localparam logic [4:0] KEY_SRC_SOFTWARE = 5'h01;
   localparam logic [4:0] KEY_SRC_FIRST_RSV = 5'h14;
   localparam int unsigned KEY_SRC_NUM     = 20;
   localparam logic [3:0] CAR_SRC_PIN      = 4'h0;
   localparam int unsigned CAR_SRC_NUM     = 16;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic       RST_BIT   = 1'b0;
   localparam logic [4:0] RST_KSRC  = 5'h00;
   localparam logic [3:0] RST_CSEL  = 4'h0;
   localparam logic [7:0] RST_RDATA = 8'h00;

   // Carrier phase, Gray coded around the keying cycle
   typedef enum logic [1:0] {
      SGMX_ON_LOWER   = 2'b00,
      SGMX_LEAVE_LOW  = 2'b01,
      SGMX_ON_UPPER   = 2'b11,
      SGMX_LEAVE_HIGH = 2'b10
   } sgmx_phase_t;

   typedef struct packed {
      logic        en;
      logic        oinv;
      logic        sbit;
      logic        hinv;
      logic        hsync;
      logic        linv;
      logic        lsync;
      logic [4:0]  ksrc;
      logic [3:0]  lsel;
      logic [3:0]  hsel;
      sgmx_phase_t phase;
      logic        pin;
      logic [7:0]  rdata;
   } sgmx_state_t;

endpackage

// file: verilog/sgmx_mixer.sv
// Signal mixer unit: register file, source selection, carrier
// synchronisation and output stage in one module.
// Assumes all source inputs are synchronous to clk_sys and that the
// power-off level comes from a power gating register elsewhere.

module sgmx_mixer
   import sgmx_pkg::*;
(
   // Clock and reset
   input  wire logic                          clk_sys,
   input  wire logic                          srst,
   // Register port
   input  wire logic [sgmx_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [sgmx_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [sgmx_pkg::DATA_W-1:0]   reg_rdata,
   // Power gating
   input  wire logic                          mixer_power_off,
   // Keying sources, index is the source code
   input  wire logic [sgmx_pkg::KEY_SRC_NUM-1:0] keying_src_in,
   // Shared carrier sources, index is the carrier code
   input  wire logic [sgmx_pkg::CAR_SRC_NUM-1:1] carrier_src_in,
   input  wire logic                          upper_carrier_pin,
   input  wire logic                          lower_carrier_pin,
   // Mixed output
   output logic                               mixed_output_pin
);

   import sgmx_pkg::*;

   // ----------------------------------------------------------------
   // Source selection
   // ----------------------------------------------------------------
   function automatic logic pick_carrier(
      input logic [3:0]              sel,
      input logic                    pin,
      input logic [CAR_SRC_NUM-1:1]  shared,
      input logic                    inv
   );
      logic v;
      v = 1'b0;
      if (sel == CAR_SRC_PIN) begin
         v = pin;
      end else begin
         v = shared[sel];
      end
      return v ^ inv;
   endfunction

   sgmx_state_t s_q;
   sgmx_state_t s_d;

   logic key_now;
   logic upper_now;
   logic lower_now;
   logic use_upper;
   logic mix_now;

   always_comb begin
      key_now = 1'b0;
      if (s_q.ksrc >= KEY_SRC_FIRST_RSV) begin
         key_now = 1'b0;
      end else if (s_q.ksrc == KEY_SRC_SOFTWARE) begin
         key_now = s_q.sbit;
      end else begin
         key_now = keying_src_in[s_q.ksrc];
      end
      upper_now = pick_carrier(s_q.hsel, upper_carrier_pin, carrier_src_in, s_q.hinv);
      // lower carrier select, shared code table
      lower_now = pick_carrier(s_q.lsel, lower_carrier_pin, carrier_src_in, s_q.linv);
      use_upper = (s_q.phase == SGMX_ON_UPPER) || (s_q.phase == SGMX_LEAVE_HIGH);
      mix_now = use_upper ? upper_now : lower_now;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d       = s_q;
      s_d.rdata = RST_RDATA;

      // Register writes
      if (reg_wr) begin
         case (reg_addr)
            OFS_MIXER_CONTROL_ZERO: begin
               s_d.en   = reg_wdata[BIT_ENABLE];
               s_d.oinv = reg_wdata[BIT_OUTPUT_INVERT];
               s_d.sbit = reg_wdata[BIT_SW_KEYING];
            end
            OFS_MIXER_CONTROL_ONE: begin
               s_d.hinv  = reg_wdata[BIT_UPPER_INVERT];
               s_d.hsync = reg_wdata[BIT_UPPER_SYNC];
               s_d.linv  = reg_wdata[BIT_LOWER_INVERT];
               s_d.lsync = reg_wdata[BIT_LOWER_SYNC];
            end
            OFS_KEYING_SOURCE_REG: begin
               s_d.ksrc = reg_wdata[KEY_FIELD_W-1:0];
            end
            OFS_LOWER_CARRIER_REG: begin
               s_d.lsel = reg_wdata[CAR_FIELD_W-1:0];
            end
            OFS_UPPER_CARRIER_REG: begin
               s_d.hsel = reg_wdata[CAR_FIELD_W-1:0];
            end
            default: begin
               s_d.en = s_q.en;
            end
         endcase
      end

      // Register reads, data valid the next cycle only
      if (reg_rd) begin
         case (reg_addr)
            OFS_MIXER_CONTROL_ZERO: begin
               s_d.rdata[BIT_ENABLE]        = s_q.en;
               s_d.rdata[BIT_OUT_STATUS]    = s_q.pin;
               s_d.rdata[BIT_OUTPUT_INVERT] = s_q.oinv;
               s_d.rdata[BIT_SW_KEYING]     = s_q.sbit;
            end
            OFS_MIXER_CONTROL_ONE: begin
               s_d.rdata[BIT_UPPER_INVERT] = s_q.hinv;
               s_d.rdata[BIT_UPPER_SYNC]   = s_q.hsync;
               s_d.rdata[BIT_LOWER_INVERT] = s_q.linv;
               s_d.rdata[BIT_LOWER_SYNC]   = s_q.lsync;
            end
            OFS_KEYING_SOURCE_REG: begin
               s_d.rdata[KEY_FIELD_W-1:0] = s_q.ksrc;
            end
            OFS_LOWER_CARRIER_REG: begin
               s_d.rdata[CAR_FIELD_W-1:0] = s_q.lsel;
            end
            OFS_UPPER_CARRIER_REG: begin
               s_d.rdata[CAR_FIELD_W-1:0] = s_q.hsel;
            end
            default: begin
               s_d.rdata = RST_RDATA;
            end
         endcase
      end

      // Carrier phase; no sync means immediate switch-over
      // finish running pulse, wait for fall
      case (s_q.phase)
         SGMX_ON_LOWER: begin
            if (key_now) begin
               s_d.phase = (s_q.lsync && lower_now) ? SGMX_LEAVE_LOW : SGMX_ON_UPPER;
            end
         end
         SGMX_LEAVE_LOW: begin
            if (!key_now) begin
               s_d.phase = SGMX_ON_LOWER;
            end else if (!lower_now) begin
               s_d.phase = SGMX_ON_UPPER;
            end
         end
         SGMX_ON_UPPER: begin
            if (!key_now) begin
               s_d.phase = (s_q.hsync && upper_now) ? SGMX_LEAVE_HIGH : SGMX_ON_LOWER;
            end
         end
         SGMX_LEAVE_HIGH: begin
            if (key_now) begin
               s_d.phase = SGMX_ON_UPPER;
            end else if (!upper_now) begin
               s_d.phase = SGMX_ON_LOWER;
            end
         end
         default: begin
            s_d.phase = SGMX_ON_LOWER;
         end
      endcase

      // pin low while disabled, inversion when enabled
      s_d.pin = s_q.en ? (mix_now ^ s_q.oinv) : 1'b0;

      if (srst || mixer_power_off) begin
         s_d.en    = RST_BIT;
         s_d.oinv  = RST_BIT;
         s_d.sbit  = RST_BIT;
         s_d.hinv  = RST_BIT;
         s_d.hsync = RST_BIT;
         s_d.linv  = RST_BIT;
         s_d.lsync = RST_BIT;
         s_d.ksrc  = RST_KSRC;
         s_d.lsel  = RST_CSEL;
         s_d.hsel  = RST_CSEL;
         s_d.phase = SGMX_ON_LOWER;
         s_d.pin   = RST_BIT;
         s_d.rdata = RST_RDATA;
      end
   end

   always_ff @(posedge clk_sys) begin
      s_q <= s_d;
   end

   assign reg_rdata        = s_q.rdata;
   assign mixed_output_pin = s_q.pin;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb_sys @(posedge clk_sys); endclocking
   default disable iff (srst);

   property p_disabled_low;
      !s_q.en |=> !mixed_output_pin;
   endproperty
   a_disabled_low: assert property (p_disabled_low)
      else $error("output not low while disabled");

   property p_enable_write;
      reg_wr && !mixer_power_off && reg_addr == OFS_MIXER_CONTROL_ZERO
         |=> s_q.en == $past(reg_wdata[BIT_ENABLE]);
   endproperty
   a_enable_write: assert property (p_enable_write)
      else $error("enable bit did not follow write");

   property p_upper_mix;
      s_q.en && !s_q.oinv && s_q.phase == SGMX_ON_UPPER && !mixer_power_off
         |=> mixed_output_pin == $past(upper_now);
   endproperty
   a_upper_mix: assert property (p_upper_mix)
      else $error("upper carrier not mixed");

   property p_lower_mix;
      s_q.en && !s_q.oinv && s_q.phase == SGMX_ON_LOWER && !mixer_power_off
         |=> mixed_output_pin == $past(lower_now);
   endproperty
   a_lower_mix: assert property (p_lower_mix)
      else $error("lower carrier not mixed");

   property p_out_invert;
      s_q.en && s_q.oinv && !mix_now && !mixer_power_off |=> mixed_output_pin;
   endproperty
   a_out_invert: assert property (p_out_invert)
      else $error("inverted output not high");

   property p_status_read;
      reg_rd && !mixer_power_off && reg_addr == OFS_MIXER_CONTROL_ZERO
         |=> reg_rdata[BIT_OUT_STATUS] == $past(mixed_output_pin);
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status bit differs from output");

   property p_sync_hold;
      s_q.phase == SGMX_ON_UPPER && !key_now && s_q.hsync && upper_now
         && !mixer_power_off |=> s_q.phase == SGMX_LEAVE_HIGH;
   endproperty
   a_sync_hold: assert property (p_sync_hold)
      else $error("sync did not hold upper carrier");

   property p_no_sync;
      s_q.phase == SGMX_ON_LOWER && key_now && !s_q.lsync && !mixer_power_off
         |=> s_q.phase == SGMX_ON_UPPER;
   endproperty
   a_no_sync: assert property (p_no_sync)
      else $error("unsynchronised switch delayed");

   property p_wait_fall;
      s_q.phase == SGMX_LEAVE_HIGH && !key_now && !upper_now && !mixer_power_off
         |=> s_q.phase == SGMX_ON_LOWER;
   endproperty
   a_wait_fall: assert property (p_wait_fall)
      else $error("switch not taken at carrier fall");

   property p_reserved_low;
      s_q.ksrc >= KEY_SRC_FIRST_RSV |-> !key_now;
   endproperty
   a_reserved_low: assert property (p_reserved_low)
      else $error("reserved keying code not low");

   property p_soft_key;
      s_q.ksrc == KEY_SRC_SOFTWARE |-> key_now == s_q.sbit;
   endproperty
   a_soft_key: assert property (p_soft_key)
      else $error("software keying bit not used");

   property p_power_off;
      mixer_power_off |=> !s_q.en && s_q.ksrc == RST_KSRC && !mixed_output_pin
         && reg_rdata == RST_RDATA;
   endproperty
   a_power_off: assert property (p_power_off)
      else $error("power-off did not restore defaults");

   property p_keep_select;
      reg_wr && !mixer_power_off && reg_addr == OFS_MIXER_CONTROL_ZERO
         && !reg_wdata[BIT_ENABLE] |=> s_q.ksrc == $past(s_q.ksrc)
         && s_q.hsel == $past(s_q.hsel) && s_q.lsel == $past(s_q.lsel);
   endproperty
   a_keep_select: assert property (p_keep_select)
      else $error("selection lost on disable");

   property p_upper_pin;
      s_q.hsel == CAR_SRC_PIN |-> upper_now == (upper_carrier_pin ^ s_q.hinv);
   endproperty
   a_upper_pin: assert property (p_upper_pin)
      else $error("upper pin carrier polarity wrong");

   property p_lower_pin;
      s_q.lsel == CAR_SRC_PIN |-> lower_now == (lower_carrier_pin ^ s_q.linv);
   endproperty
   a_lower_pin: assert property (p_lower_pin)
      else $error("lower pin carrier polarity wrong");

   property p_upper_select;
      s_q.hsel != CAR_SRC_PIN |-> upper_now == (carrier_src_in[s_q.hsel] ^ s_q.hinv);
   endproperty
   a_upper_select: assert property (p_upper_select)
      else $error("upper carrier source wrong");

   property p_lower_select;
      s_q.lsel != CAR_SRC_PIN |-> lower_now == (carrier_src_in[s_q.lsel] ^ s_q.linv);
   endproperty
   a_lower_select: assert property (p_lower_select)
      else $error("lower carrier source wrong");

   property p_pin_key;
      s_q.ksrc == KEY_SRC_PIN |-> key_now == keying_src_in[KEY_SRC_PIN];
   endproperty
   a_pin_key: assert property (p_pin_key)
      else $error("keying pin not used");

   property p_reset_default;
      disable iff (1'b0)
      srst |=> !s_q.en && s_q.ksrc == RST_KSRC && s_q.hsel == RST_CSEL
         && s_q.lsel == RST_CSEL && !mixed_output_pin && reg_rdata == RST_RDATA;
   endproperty
   a_reset_default: assert property (p_reset_default)
      else $error("reset did not restore defaults");

   property p_sync_hold_low;
      s_q.phase == SGMX_ON_LOWER && key_now && s_q.lsync && lower_now
         && !mixer_power_off |=> s_q.phase == SGMX_LEAVE_LOW;
   endproperty
   a_sync_hold_low: assert property (p_sync_hold_low)
      else $error("sync did not hold lower carrier");

   property p_wait_fall_low;
      s_q.phase == SGMX_LEAVE_LOW && key_now && !lower_now && !mixer_power_off
         |=> s_q.phase == SGMX_ON_UPPER;
   endproperty
   a_wait_fall_low: assert property (p_wait_fall_low)
      else $error("switch not taken at lower carrier fall");

   property p_no_sync_high;
      s_q.phase == SGMX_ON_UPPER && !key_now && !s_q.hsync && !mixer_power_off
         |=> s_q.phase == SGMX_ON_LOWER;
   endproperty
   a_no_sync_high: assert property (p_no_sync_high)
      else $error("unsynchronised fall delayed");

   property p_read_idle;
      !reg_rd |=> reg_rdata == RST_RDATA;
   endproperty
   a_read_idle: assert property (p_read_idle)
      else $error("read data stands without a read");

   c_sync_wait: cover property (s_q.phase == SGMX_LEAVE_HIGH ##1 s_q.phase == SGMX_ON_LOWER);
   c_low_wait: cover property (s_q.phase == SGMX_LEAVE_LOW ##1 s_q.phase == SGMX_ON_UPPER);
   c_soft_key: cover property (s_q.ksrc == KEY_SRC_SOFTWARE && s_q.en ##1 mixed_output_pin);
   c_power_off: cover property (s_q.en ##1 mixer_power_off);
   c_out_invert: cover property (s_q.en && s_q.oinv ##1 mixed_output_pin);

endmodule

// file: verif/sgmx_src_model.sv
// Source model: peripheral outputs and pins feeding the signal mixer.
// Assumes the bench sets wanted levels; slow mode delays them one cycle.
module sgmx_src_model (
   // Clock and mode
   input  wire logic                              clk_sys,
   input  wire logic                              slow,
   // Wanted levels from the bench
   input  wire logic [sgmx_pkg::KEY_SRC_NUM-1:0]  key_lvl,
   input  wire logic [sgmx_pkg::CAR_SRC_NUM-1:1]  car_lvl,
   input  wire logic [1:0]                        pin_lvl,
   // Levels seen by the mixer
   output logic      [sgmx_pkg::KEY_SRC_NUM-1:0]  keying_src_in,
   output logic      [sgmx_pkg::CAR_SRC_NUM-1:1]  carrier_src_in,
   output logic                                   upper_carrier_pin,
   output logic                                   lower_carrier_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   import sgmx_pkg::*;

   logic [KEY_SRC_NUM+CAR_SRC_NUM:0] lvl_q = '0;
   logic [KEY_SRC_NUM+CAR_SRC_NUM:0] lvl_d;

   // --------------------------------------------------------------
   // Source levels
   // --------------------------------------------------------------
   assign lvl_d = {key_lvl, car_lvl, pin_lvl};

   always @(posedge clk_sys) begin
      lvl_q <= lvl_d;
   end

   assign {keying_src_in, carrier_src_in, upper_carrier_pin, lower_carrier_pin} =
      slow ? lvl_q : lvl_d;
endmodule

// file: verif/test_data_signal_modulator.sv
// Bench for the signal mixer unit: register tasks and mixing checks.
// Assumes sgmx_pkg, sgmx_mixer and sgmx_src_model are compiled first.
module test_data_signal_modulator;
   timeunit 1ns;
   timeprecision 1ps;
   import sgmx_pkg::*;

   // --------------------------------------------------------------
   // Signals
   // --------------------------------------------------------------
   localparam logic [7:0] RB_MASK [7] = '{8'h00, 8'h11, 8'h33, 8'h1F, 8'h0F, 8'h0F, 8'h00};
   logic                   clk_sys         = 1'h0;
   logic                   srst            = 1'h1;
   logic [ADDR_W-1:0]      reg_addr        = 12'h000;
   logic [DATA_W-1:0]      reg_wdata       = 8'h00;
   logic                   reg_wr          = 1'h0;
   logic                   reg_rd          = 1'h0;
   logic                   mixer_power_off = 1'h0;
   logic                   slow            = 1'h1;
   logic [KEY_SRC_NUM-1:0] key_lvl         = 20'h00000;
   logic [CAR_SRC_NUM-1:1] car_lvl         = 15'h0000;
   logic [1:0]             pin_lvl         = 2'h0;
   logic [DATA_W-1:0]      reg_rdata;
   logic [KEY_SRC_NUM-1:0] keying_src_in;
   logic [CAR_SRC_NUM-1:1] carrier_src_in;
   logic                   upper_carrier_pin;
   logic                   lower_carrier_pin;
   logic                   mixed_output_pin;
   logic [19:0]            oh;
   logic [15:0]            t;
   logic                   pv;
   int                     err_total       = 0;
   int                     samples_checked = 0;

   always #4 clk_sys = ~clk_sys;

   sgmx_src_model i_src (.clk_sys(clk_sys), .slow(slow), .key_lvl(key_lvl),
      .car_lvl(car_lvl), .pin_lvl(pin_lvl), .keying_src_in(keying_src_in),
      .carrier_src_in(carrier_src_in), .upper_carrier_pin(upper_carrier_pin),
      .lower_carrier_pin(lower_carrier_pin));

   sgmx_mixer i_dut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .mixer_power_off(mixer_power_off), .keying_src_in(keying_src_in),
      .carrier_src_in(carrier_src_in), .upper_carrier_pin(upper_carrier_pin),
      .lower_carrier_pin(lower_carrier_pin), .mixed_output_pin(mixed_output_pin));

   // --------------------------------------------------------------
   // Tasks
   // --------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      #1;
      chk(reg_rdata, exp, "read data");
   endtask

   task automatic out_chk(input logic exp);
      repeat (4) @(posedge clk_sys);
      #1;
      chk({7'h00, mixed_output_pin}, {7'h00, exp}, "mixed output");
   endtask

   task automatic setsrc(input logic [19:0] k, input logic [15:1] c, input logic [1:0] p);
      @(posedge clk_sys);
      key_lvl <= k;
      car_lvl <= c;
      pin_lvl <= p;
   endtask

   task automatic done(input string name);
      $display("test %s finished", name);
   endtask

   task automatic results();
      $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // --------------------------------------------------------------
   // Tests
   // --------------------------------------------------------------
   initial begin
      repeat (10000) @(posedge clk_sys);
      err_total++;
      results();
   end

   initial begin
      repeat (2) @(posedge clk_sys);
      srst <= 1'h0;
      for (int i = 0; i < 7; i++) begin
         rd_chk(12'h896 + 12'(i), 8'h00);
      end
      for (int i = 0; i < 7; i++) begin
         wr(12'h896 + 12'(i), (i == 1) ? 8'h7F : 8'hFF);
         rd_chk(12'h896 + 12'(i), RB_MASK[i]);
      end
      @(posedge clk_sys);
      srst <= 1'h1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'h0;
      for (int i = 0; i < 7; i++) begin
         rd_chk(12'h896 + 12'(i), 8'h00);
      end
      done("registers");
      wr(12'h897, 8'h90);
      out_chk(1'h1);
      rd_chk(12'h897, 8'hB0);
      @(posedge clk_sys);
      mixer_power_off <= 1'h1;
      wr(12'h897, 8'h80);
      out_chk(1'h0);
      @(posedge clk_sys);
      mixer_power_off <= 1'h0;
      rd_chk(12'h897, 8'h00);
      done("power gate");
      wr(12'h89B, 8'h02);
      wr(12'h89A, 8'h03);
      wr(12'h897, 8'h81);
      for (int c = 0; c < 32; c++) begin
         for (int p = 0; p < 2; p++) begin
            oh = (c < 20) ? 20'h00001 << c : 20'h00000;
            wr(12'h899, 8'(c));
            setsrc(p ? ~oh : oh, 15'h0002, 2'h0);
            out_chk(c == 1 || (c < 20 && p == 0));
         end
      end
      done("keying sources");
      slow <= 1'h0;
      wr(12'h899, 8'h01);
      for (int h = 0; h < 2; h++) begin
         for (int s = 0; s < 16; s++) begin
            for (int m = 0; m < 4; m++) begin
               t = 16'h0001 << s;
               pv = (s == 0) ? m[0] : ~m[0];
               wr(h ? 12'h89B : 12'h89A, 8'(s));
               wr(12'h898, m[1] ? (h ? 8'h20 : 8'h02) : 8'h00);
               wr(12'h897, h ? 8'h81 : 8'h80);
               setsrc(20'h00000, m[0] ? t[15:1] : ~t[15:1],
                      h ? {pv, ~m[0]} : {~m[0], pv});
               out_chk(m[0] ^ m[1]);
            end
         end
      end
      done("carrier sources");
      slow <= 1'h1;
      wr(12'h89B, 8'h02);
      wr(12'h89A, 8'h03);
      wr(12'h898, 8'h10);
      wr(12'h897, 8'h81);
      setsrc(20'h00000, 15'h0002, 2'h0);
      out_chk(1'h1);
      wr(12'h897, 8'h80);
      out_chk(1'h1);
      setsrc(20'h00000, 15'h0000, 2'h0);
      out_chk(1'h0);
      setsrc(20'h00000, 15'h0002, 2'h0);
      out_chk(1'h0);
      wr(12'h898, 8'h01);
      setsrc(20'h00000, 15'h0004, 2'h0);
      out_chk(1'h1);
      wr(12'h897, 8'h81);
      out_chk(1'h1);
      setsrc(20'h00000, 15'h0000, 2'h0);
      out_chk(1'h0);
      setsrc(20'h00000, 15'h0002, 2'h0);
      out_chk(1'h1);
      wr(12'h897, 8'h80);
      out_chk(1'h0);
      done("carrier sync");
      wr(12'h897, 8'h81);
      out_chk(1'h1);
      wr(12'h897, 8'h01);
      out_chk(1'h0);
      rd_chk(12'h89B, 8'h02);
      wr(12'h897, 8'h81);
      out_chk(1'h1);
      done("enable");
      results();
   end
endmodule
